// File: include/nv_seq_pkg.sv
/*
 * Constants shared by the nonvolatile store and recall sequencer.
 * Assumes a 200 MHz core clock; every timing count below but SYNC_LAT is
 * derived from a printed time and that clock period.
 */
package nv_seq_pkg;

	// Core clock period in nanoseconds.
	localparam real CLK_PERIOD_NS = 5.0;

	// Printed times, each in its own unit.
	localparam real T_FA_MS      = 20.00;  // Power-up recall, longest.
	localparam real T_STORE_MS   = 8.00;   // Store cycle, longest.
	localparam real T_DELAY_NS   = 25.00;  // Accesses kept before store.
	localparam real T_LZHSB_US   = 5.00;   // Pin high to available.
	localparam real T_HHHD_NS    = 500.00; // Active high drive of the pin.
	localparam real T_WAKE_MS    = 20.00;  // Hibernate wake-up, longest.
	localparam real T_HIB_ENTRY_MS = 8.00; // Hibernate entry, longest.
	localparam real T_RECALL_US  = 500.0;  // Software recall, longest.

	// Longest times round down to whole cycles.
	localparam int FA_CYC     = int'($floor(T_FA_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int STORE_CYC  =
		int'($floor(T_STORE_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int DELAY_CYC  = int'($floor(T_DELAY_NS / CLK_PERIOD_NS));
	localparam int LZHSB_CYC  =
		int'($floor(T_LZHSB_US * 1.0e3 / CLK_PERIOD_NS));
	localparam int HHHD_CYC   = int'($floor(T_HHHD_NS / CLK_PERIOD_NS));
	localparam int WAKE_CYC   = int'($floor(T_WAKE_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int HIB_ENTRY_CYC =
		int'($floor(T_HIB_ENTRY_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int RECALL_CYC =
		int'($floor(T_RECALL_US * 1.0e3 / CLK_PERIOD_NS));

	// Width of the shared interval timer; holds the longest count.
	localparam int TMR_W = 22;

	// Number of synchroniser lanes and the pins that pass through them.
	localparam int SYNC_N   = 3;
	localparam int SYNC_SUP = 0;  // Supply above trigger level.
	localparam int SYNC_PIN = 1;  // Level sensed on the store/busy pin.
	localparam int SYNC_CS  = 2;  // Chip select, active low.

	// Worst-case cycles from a pin change to the state register: two
	// synchroniser stages and the edge detect. Phases timed from a pin
	// give these cycles back so the printed limit still holds.
	localparam int SYNC_LAT = 3;

	// Software sequence commands from the serial decoder.
	typedef enum logic [2:0] {
		CMD_STORE     = 3'h1,
		CMD_RECALL    = 3'h2,
		CMD_HIBERNATE = 3'h3,
		CMD_SLEEP     = 3'h4
	} cmd_t;

	// Sequencer states, Gray coded along the usual path.
	typedef enum logic [3:0] {
		ST_POWER_DOWN  = 4'h0,
		ST_PWRUP_RCL   = 4'h1,
		ST_READY       = 4'h3,
		ST_STORE_DELAY = 4'h2,
		ST_STORE       = 4'h6,
		ST_PIN_HIGH    = 4'h7,
		ST_SW_RECALL   = 4'h4,
		ST_HIB_ENTER   = 4'hC,
		ST_HIBERNATE   = 4'hD,
		ST_WAKE        = 4'hF
	} state_t;

endpackage

// File: src/nv_interval_timer.sv
/*
 * Down-counting interval timer used by the sequencer for every phase.
 * Assumes the caller loads it only when a phase starts; a fresh load
 * restarts the count.
 */
`timescale 1ns/1ps
module nv_interval_timer
	import nv_seq_pkg::*;
#(
	parameter int W = TMR_W
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              expired_q
);

	logic [W-1:0] cnt_q;  // Cycles left in the running phase.

	// Count down to zero; a load overrides the count in progress.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= load_val;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - W'(1);
		end
	end

	// One-cycle pulse as the count runs out, so the phase ends once.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			expired_q <= 1'b0;
		end else begin
			expired_q <= !load && (cnt_q == W'(1));
		end
	end

endmodule // nv_interval_timer

// File: src/nv_store_recall_sequencer.sv
/*
 * Store and recall sequencer between the SRAM array and its
 * nonvolatile shadow. Assumes a serial decoder on the same clock that
 * hands over decoded commands and SRAM write strikes, and raw pins for
 * the supply comparator, chip select and the store/busy pin.
 */
`timescale 1ns/1ps
module nv_store_recall_sequencer
	import nv_seq_pkg::*;
#(
	parameter int unsigned FA_CYCLES     = FA_CYC,
	parameter int unsigned STORE_CYCLES  = STORE_CYC,
	parameter int unsigned WAKE_CYCLES   = WAKE_CYC,
	parameter int unsigned HIB_ENTRY_CYCLES = HIB_ENTRY_CYC,
	parameter int unsigned RECALL_CYCLES = RECALL_CYC
) (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       supply_above_trigger,
	input  wire logic       cs_n,
	input  wire logic       store_busy_pin_lvl,
	input  wire logic       cmd_valid,
	input  wire logic [2:0] cmd_code,
	input  wire logic       sram_write,
	output logic            store_busy_pin_drv_q,
	output logic            store_busy_pin_en_q,
	output logic            access_inhibit_window_q,
	output logic            array_store_q,
	output logic            array_recall_q,
	output logic            hibernate_q,
	output logic            sleep_q,
	output logic            ready_q
);

	// Raw pins pass two flops before any logic looks at them.
	logic [SYNC_N-1:0] meta_q;   // First stage, read only by sync_q.
	logic [SYNC_N-1:0] sync_q;   // Second stage, safe to use.
	logic [SYNC_N-1:0] prev_q;   // Previous synchronised value.

	state_t       state_q;       // Current sequencer state.
	state_t       state_d;       // Next sequencer state.
	logic         dirty_q;       // SRAM written since last nv cycle.
	logic         sleep_armed_q; // Sleep command awaits chip select.
	logic         tmr_load;      // Start a timed phase.
	logic [TMR_W-1:0] tmr_val;   // Timer load for that phase, one less than its length.
	logic         tmr_done;      // Timed phase has run out.

	logic sup_ok;      // Supply above its trigger level.
	logic pin_fall;    // Host began a hardware store request.
	logic cs_rise;     // Chip select returned high.
	logic cs_fall;     // Chip select went low.
	logic cmd_take;    // A software command is taken this cycle.

	// Tell whether a state lets the serial side reach the SRAM.
	function automatic logic access_open(input state_t s);
		return (s == ST_READY) || (s == ST_STORE_DELAY);
	endfunction

	// Timer load for a phase of n cycles. The timer ends a phase one
	// cycle after its count runs out, so loading n - 1 keeps each phase
	// at exactly n cycles and never beyond the longest printed time.
	function automatic logic [TMR_W-1:0] phase_len(input int unsigned n);
		return TMR_W'(n - 1);
	endfunction

	// Two-flop synchronisers, one lane per pin.
	generate
		for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					// Start at each pin's idle level, so that no false
					// edge is seen as the first samples arrive.
					meta_q[i] <= (i == SYNC_SUP) ? 1'b0 : 1'b1;
					sync_q[i] <= (i == SYNC_SUP) ? 1'b0 : 1'b1;
					prev_q[i] <= (i == SYNC_SUP) ? 1'b0 : 1'b1;
				end else begin
					meta_q[i] <= (i == SYNC_SUP) ?
						supply_above_trigger :
						(i == SYNC_PIN) ? store_busy_pin_lvl : cs_n;
					sync_q[i] <= meta_q[i];
					prev_q[i] <= sync_q[i];
				end
			end
		end
	endgenerate

	// Edges of the synchronised pins. The pin is only watched while
	// we are not driving it ourselves, so our own low is no request.
	assign sup_ok   = sync_q[SYNC_SUP];
	assign pin_fall = prev_q[SYNC_PIN] && !sync_q[SYNC_PIN] &&
		!store_busy_pin_en_q;
	assign cs_rise  = !prev_q[SYNC_CS] && sync_q[SYNC_CS];
	assign cs_fall  = prev_q[SYNC_CS] && !sync_q[SYNC_CS];

	// Commands are acted on the cycle they arrive, far inside 500 us.
	assign cmd_take = cmd_valid && (state_q == ST_READY) && !sleep_q;

	// Next state and the phase timer load.
	always_comb begin
		state_d  = state_q;
		tmr_load = 1'b0;
		tmr_val  = '0;
		case (state_q)
			ST_POWER_DOWN: begin
				// Recall starts as the supply crosses its trigger level.
				if (sup_ok) begin
					state_d  = ST_PWRUP_RCL;
					tmr_load = 1'b1;
					// Measured from the supply crossing, so the
					// synchroniser latency comes off the phase.
					tmr_val  = phase_len(FA_CYCLES - SYNC_LAT);
				end
			end
			ST_PWRUP_RCL: begin
				// A brown-out during recall starts over from power down.
				if (!sup_ok) begin
					state_d = ST_POWER_DOWN;
				end else if (tmr_done) begin
					state_d = ST_READY;
				end
			end
			ST_READY: begin
				if (!sup_ok || pin_fall) begin
					// Power fail or pin store: only with unsaved data.
					if (dirty_q) begin
						state_d  = ST_STORE_DELAY;
						tmr_load = 1'b1;
						// Accesses were already open while the pin
						// passed the synchroniser; count that too.
						tmr_val  = phase_len(DELAY_CYC - SYNC_LAT);
					end else if (!sup_ok) begin
						state_d = ST_POWER_DOWN;
					end
				end else if (cmd_take) begin
					case (cmd_code)
						CMD_STORE: begin
							state_d  = ST_STORE;
							tmr_load = 1'b1;
							tmr_val  = phase_len(STORE_CYCLES);
						end
						CMD_RECALL: begin
							state_d  = ST_SW_RECALL;
							tmr_load = 1'b1;
							tmr_val  = phase_len(RECALL_CYCLES);
						end
						CMD_HIBERNATE: begin
							state_d  = ST_HIB_ENTER;
							tmr_load = 1'b1;
							tmr_val  = phase_len(HIB_ENTRY_CYCLES);
						end
						default: begin
							state_d = ST_READY;
						end
					endcase
				end
			end
			ST_STORE_DELAY: begin
				// Accesses still run here while the supply holds; the store then takes over.
				if (tmr_done) begin
					state_d  = ST_STORE;
					tmr_load = 1'b1;
					tmr_val  = phase_len(STORE_CYCLES);
				end
			end
			ST_STORE: begin
				// The store runs on the hold-up capacitor, so a low
				// supply does not cut it short.
				if (tmr_done) begin
					state_d  = ST_PIN_HIGH;
					tmr_load = 1'b1;
					tmr_val  = phase_len(HHHD_CYC);
				end
			end
			ST_PIN_HIGH: begin
				// Release the pin and reopen at once if the supply holds, well under 5 us.
				if (tmr_done) begin
					state_d = sup_ok ? ST_READY : ST_POWER_DOWN;
				end
			end
			ST_SW_RECALL: begin
				if (!sup_ok) begin
					state_d = ST_POWER_DOWN;
				end else if (tmr_done) begin
					state_d = ST_READY;
				end
			end
			ST_HIB_ENTER: begin
				if (tmr_done) begin
					state_d = ST_HIBERNATE;
				end
			end
			ST_HIBERNATE: begin
				// Chip select going low wakes the part.
				if (cs_fall) begin
					state_d  = ST_WAKE;
					tmr_load = 1'b1;
					// Wake-up begins at the pin, before the synchroniser.
					tmr_val  = phase_len(WAKE_CYCLES - SYNC_LAT);
				end
			end
			ST_WAKE: begin
				if (tmr_done) begin
					state_d = ST_READY;
				end
			end
			default: begin
				state_d = ST_POWER_DOWN;
			end
		endcase
		// A supply below trigger outside a store ends any phase.
		if (!sup_ok && (state_d != ST_STORE) &&
			(state_d != ST_STORE_DELAY) && (state_d != ST_PIN_HIGH)) begin
			state_d  = ST_POWER_DOWN;
			tmr_load = 1'b0;
		end
	end

	// One timer serves every phase since phases never overlap.
	nv_interval_timer #(
		.W (TMR_W)
	) u_timer (
		.clk       (clk),
		.rstn      (rstn),
		.load      (tmr_load),
		.load_val  (tmr_val),
		.expired_q (tmr_done)
	);

	// State register.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_POWER_DOWN;
		end else begin
			state_q <= state_d;
		end
	end

	// Unsaved-data flag. A write in the cycle a cycle ends wins, so
	// that data is never marked clean before it reaches the shadow.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dirty_q <= 1'b0;
		end else if (sram_write && access_open(state_q) && sup_ok) begin
			dirty_q <= 1'b1;
		end else if (tmr_done && ((state_q == ST_STORE) ||
			(state_q == ST_SW_RECALL) || (state_q == ST_PWRUP_RCL))) begin
			dirty_q <= 1'b0;
		end
	end

	// Sleep: armed by the command, entered and left on chip select
	// rising, with no added wait beyond the synchroniser.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sleep_armed_q <= 1'b0;
			sleep_q       <= 1'b0;
		end else if (state_d != ST_READY) begin
			sleep_armed_q <= 1'b0;
			sleep_q       <= 1'b0;
		end else if (cmd_take && (cmd_code == CMD_SLEEP)) begin
			sleep_armed_q <= 1'b1;
		end else if (cs_rise && sleep_armed_q) begin
			sleep_armed_q <= 1'b0;
			sleep_q       <= 1'b1;
		end else if (cs_rise && sleep_q) begin
			sleep_q       <= 1'b0;
		end
	end

	// Store/busy pin: low while a store runs, then driven high for a
	// short while and released to the external pull-up.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			store_busy_pin_drv_q <= 1'b1;
			store_busy_pin_en_q  <= 1'b0;
		end else begin
			store_busy_pin_drv_q <= (state_d == ST_PIN_HIGH);
			store_busy_pin_en_q  <= (state_d == ST_STORE) ||
				(state_d == ST_PIN_HIGH);
		end
	end

	// Status outputs, all taken from the next state so they change
	// with the state register.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			access_inhibit_window_q <= 1'b1;
			array_store_q           <= 1'b0;
			array_recall_q          <= 1'b0;
			hibernate_q             <= 1'b0;
			ready_q                 <= 1'b0;
		end else begin
			access_inhibit_window_q <= !access_open(state_d) || !sup_ok;
			array_store_q  <= (state_d == ST_STORE);
			array_recall_q <= (state_d == ST_PWRUP_RCL) ||
				(state_d == ST_SW_RECALL);
			hibernate_q    <= (state_d == ST_HIBERNATE);
			ready_q        <= (state_d == ST_READY) && sup_ok;
		end
	end

endmodule // nv_store_recall_sequencer

// File: sim/nv_seq_asserts.sv
/* Port checker for the store and recall sequencer.
   Assumes it is bound to the sequencer with shortened counts. */
`timescale 1ns/1ps
module nv_seq_asserts
	import nv_seq_pkg::*;
#(
	parameter int unsigned FA_CYCLES    = FA_CYC,
	parameter int unsigned STORE_CYCLES = STORE_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic supply_above_trigger,
	input wire logic store_busy_pin_drv_q,
	input wire logic store_busy_pin_en_q,
	input wire logic access_inhibit_window_q,
	input wire logic array_store_q,
	input wire logic array_recall_q,
	input wire logic hibernate_q,
	input wire logic ready_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	int n_st; // Cycles of the running store.
	int n_rc; // Cycles of the running recall.
	int n_hi; // Cycles of active high drive.
	// Phase lengths are counted, since they exceed a repetition.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			n_st <= 0;
			n_rc <= 0;
			n_hi <= 0;
		end else begin
			n_st <= array_store_q ? n_st + 1 : 0;
			n_rc <= array_recall_q ? n_rc + 1 : 0;
			n_hi <= (store_busy_pin_en_q && store_busy_pin_drv_q &&
				!array_store_q) ? n_hi + 1 : 0;
		end
	end
	a_store_len: assert property (n_st <= STORE_CYCLES)
		else $error("store phase too long");
	a_recall_len: assert property (n_rc <= FA_CYCLES)
		else $error("recall phase too long");
	a_high_len: assert property (n_hi <= HHHD_CYC)
		else $error("pin driven high too long");
	a_store_lock: assert property (array_store_q |->
		access_inhibit_window_q && store_busy_pin_en_q &&
		!store_busy_pin_drv_q) else $error("store without lockout");
	a_recall_lock: assert property (array_recall_q |->
		access_inhibit_window_q && !ready_q)
		else $error("recall without lockout");
	a_store_high: assert property ($fell(array_store_q) |->
		store_busy_pin_en_q && store_busy_pin_drv_q)
		else $error("no high drive after store");
	a_release_ready: assert property ($fell(store_busy_pin_en_q) &&
		supply_above_trigger |-> ready_q)
		else $error("not ready at pin release");
	a_ready_open: assert property (ready_q |->
		!access_inhibit_window_q && !hibernate_q)
		else $error("ready while inhibited");
	a_low_supply: assert property ((!supply_above_trigger)[*8]
		|=> access_inhibit_window_q) else $error("low supply open");
endmodule // nv_seq_asserts

bind nv_store_recall_sequencer nv_seq_asserts #(
	.FA_CYCLES(FA_CYCLES),
	.STORE_CYCLES(STORE_CYCLES)
) chk (
	.clk(clk),
	.rstn(rstn),
	.supply_above_trigger(supply_above_trigger),
	.store_busy_pin_drv_q(store_busy_pin_drv_q),
	.store_busy_pin_en_q(store_busy_pin_en_q),
	.access_inhibit_window_q(access_inhibit_window_q),
	.array_store_q(array_store_q),
	.array_recall_q(array_recall_q),
	.hibernate_q(hibernate_q),
	.ready_q(ready_q)
);

// File: sim/nv_host_model.sv
/* Host controller model: chip select and the store/busy wire.
   Assumes the bench calls its tasks just after a clock edge. */
`timescale 1ns/1ps
module nv_host_model (
	input  wire logic pin_drv,
	input  wire logic pin_en,
	output logic      cs_n,
	output logic      pin_lvl
);
	logic pull_q = 1'b0; // Host holds the wire low.
	initial cs_n = 1'b1;
	// Device drive wins; otherwise host pull-down, else the pull-up.
	assign pin_lvl = pin_en ? pin_drv : !pull_q;
	// A store request pulse; the caller keeps it within 15 to 600 ns.
	task automatic store_req(input int ns);
		pull_q = 1'b1;
		#(ns);
		pull_q = 1'b0;
	endtask
	// One framed select of 50 ns; issued to wake the device from hibernate and to enter and leave sleep.
	task automatic cs_pulse();
		cs_n = 1'b0;
		#50;
		cs_n = 1'b1;
	endtask
endmodule // nv_host_model

// File: sim/test_nv_store_recall_sequencer.sv
/* Scenario bench for the store and recall sequencer.
   Assumes shortened counts and the host model for the pins. */
`timescale 1ns/1ps
module test_nv_store_recall_sequencer;
	import nv_seq_pkg::*;
	localparam int FA = 20;
	localparam int ST = 30;
	localparam int WK = 20;
	localparam int HB = 10;
	localparam int RC = 15;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic supply = 1'b0;
	logic cmd_valid = 1'b0;
	logic [2:0] cmd_code = 3'h0;
	logic sram_write = 1'b0;
	logic cs_n, lvl, drv, en, inh, sto, rcl, hib, slp, rdy;
	int n_fail = 0;
	int n_compared = 0;
	int n;
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
	always #2.5 clk = !clk;
	nv_host_model host (.pin_drv(drv), .pin_en(en), .cs_n(cs_n),
		.pin_lvl(lvl));
	nv_store_recall_sequencer #(.FA_CYCLES(FA), .STORE_CYCLES(ST),
		.WAKE_CYCLES(WK), .HIB_ENTRY_CYCLES(HB), .RECALL_CYCLES(RC)) uut (
		.clk(clk), .rstn(rstn), .supply_above_trigger(supply),
		.cs_n(cs_n), .store_busy_pin_lvl(lvl), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .sram_write(sram_write),
		.store_busy_pin_drv_q(drv), .store_busy_pin_en_q(en),
		.access_inhibit_window_q(inh), .array_store_q(sto),
		.array_recall_q(rcl), .hibernate_q(hib), .sleep_q(slp),
		.ready_q(rdy));
	// Inputs always move one nanosecond after the rising edge.
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// Cycles until the chosen output reaches a level, bounded.
	task automatic wait_for(input int s, input logic v);
		logic [5:0] o;
		n = 0;
		o = {en, slp, hib, rcl, sto, rdy};
		while (o[s] !== v && n < 2000) begin
			tick(1);
			n++;
			o = {en, slp, hib, rcl, sto, rdy};
		end
		// A wait that runs out is a hang: count it and end the run.
		if (n >= 2000) begin
			n_fail++;
			end_sim();
		end
	endtask
	task automatic cmd(input cmd_t c);
		cmd_valid = 1'b1;
		cmd_code = c;
		tick(1);
		cmd_valid = 1'b0;
	endtask
	task automatic write_strike();
		sram_write = 1'b1;
		tick(1);
		sram_write = 1'b0;
	endtask
	// Store length, high drive, then release with the given readiness.
	task automatic store_chk(input logic r);
		wait_for(1, 1'b0);
		`CHK(n, ST)
		`CHK(en & drv, 1'b1)
		wait_for(5, 1'b0);
		`CHK(n, HHHD_CYC)
		`CHK(rdy, r)
	endtask
	task automatic t_power_up();
		supply = 1'b1;
		tick(5);
		`CHK(rcl & inh, 1'b1)
		wait_for(0, 1'b1);
		// Five cycles already passed since the supply rose.
		`CHK(n + 5 <= FA, 1'b1)
		$display("test power_up done");
	endtask
	// A pin request with no write since the last cycle is skipped.
	task automatic t_pin_store();
		host.store_req(100);
		tick(20);
		`CHK(sto | !rdy, 1'b0)
		write_strike();
		host.store_req(20);
		wait_for(1, 1'b1);
		// The 20 ns request already spanned four cycles.
		`CHK(n + 4 <= DELAY_CYC, 1'b1)
		store_chk(1'b1);
		$display("test pin_store done");
	endtask
	task automatic t_soft();
		cmd(CMD_STORE);
		wait_for(1, 1'b1);
		`CHK(n <= 1, 1'b1)
		store_chk(1'b1);
		cmd(CMD_RECALL);
		`CHK(rcl & inh, 1'b1)
		cmd(CMD_STORE);
		wait_for(2, 1'b0);
		`CHK(n + 1, RC)
		tick(3);
		`CHK(sto, 1'b0)
		$display("test soft done");
	endtask
	task automatic t_hib_sleep();
		cmd(CMD_HIBERNATE);
		wait_for(3, 1'b1);
		`CHK(n, HB)
		host.cs_pulse();
		wait_for(0, 1'b1);
		// The select pulse itself lasted ten cycles of the wake-up.
		`CHK(n + 10 <= WK, 1'b1)
		cmd(CMD_SLEEP);
		host.cs_pulse();
		wait_for(4, 1'b1);
		`CHK(n <= 4, 1'b1)
		host.cs_pulse();
		wait_for(4, 1'b0);
		`CHK(n <= 4, 1'b1)
		$display("test hib_sleep done");
	endtask
	// Supply loss after a write stores, then powers down.
	task automatic t_power_fail();
		write_strike();
		supply = 1'b0;
		wait_for(1, 1'b1);
		`CHK(n <= DELAY_CYC, 1'b1)
		store_chk(1'b0);
		tick(3);
		`CHK(inh & !rdy, 1'b1)
		$display("test power_fail done");
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// The tests take about 2.7 us; far beyond that the run is hung.
	initial begin
		#40us;
		n_fail++;
		end_sim();
	end
	initial begin
		tick(3);
		rstn = 1'b1;
		tick(2);
		t_power_up();
		t_pin_store();
		t_soft();
		t_hib_sleep();
		t_power_fail();
		end_sim();
	end
endmodule // test_nv_store_recall_sequencer
